// [src/step_dir_microstep_sequencer.sv]
// Purpose: step/dir front end with sine-table position and interpolation
// Assumes: resolution code 0 = 256 per full step up to 8 = full step
// Notes:   coil currents come from a table outside, indexed by o_position
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - of the two step edges, only rising ones move the position
// - step and direction pass a synchroniser before use
// - position indexes a 1024 entry table, four full steps
// - direction low adds step width, high subtracts it
// - step width is two to the power of the resolution code, held at 256 for codes above 8
// - coarser resolution snaps position to nearest valid point, except during or at the start of a microstep burst
// - full steps sit at 128, 384, 640, 896, moving 256
// - half steps start at 64 by 128; quarter at 32 by 64
// - full and half step points give the documented coil magnitudes
// - each edge while moving becomes evenly spaced single-entry microsteps
// - two to 256 microsteps per input pulse by resolution
// - interval over 2^20 clocks is a standstill event
// - standstill starts standby reduction only when power-down select set
// - standstill flag sets on detection, clears on next edge
// - spacing adapts after one interval; unissued microsteps land as one jump
// - index active at position zero, once per electrical period
module step_dir_microstep_sequencer (
	input  wire logic                           i_core_clk, // core clock
	input  wire logic                           i_reset,    // sync reset
	input  wire logic                           i_step,     // step pin
	input  wire logic                           i_dir,      // direction pin
	input  wire logic [step_seq_pkg::RES_W-1:0] i_res,      // resolution
	input  wire logic                    i_power_down_select_pin, // standby
	input  wire logic                           i_interp_en, // interpolate
	output logic [step_seq_pkg::POS_W-1:0]      o_position, // table index
	output logic                                o_standstill, // stst flag
	output logic                                o_standby,  // reduce current
	output logic                                o_index     // zero point
);
	step_sync_if sync_bus ();

	step_input_sync u_sync (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_step     (i_step),
		.i_dir      (i_dir),
		.sync_port  (sync_bus)
	);

	logic [step_seq_pkg::POS_W-1:0]   pos;
	logic [step_seq_pkg::POS_W-1:0]   next_pos;
	logic [step_seq_pkg::RES_W-1:0]   res_prev;
	logic [step_seq_pkg::TIMER_W-1:0] interval;   // clocks since last edge
	logic [step_seq_pkg::TIMER_W-1:0] period;     // last measured interval
	logic [step_seq_pkg::TIMER_W-1:0] mstep_tmr;  // clocks to next microstep
	logic [8:0]                       mstep_left; // microsteps still owed
	logic                             mdir;       // direction of this burst
	step_seq_pkg::motion_state_type   state;
	logic                             index_q;

	// step width for a resolution code, saturating at full step
	function automatic logic [step_seq_pkg::POS_W-1:0] width_of(
		input logic [step_seq_pkg::RES_W-1:0] r);
		logic [step_seq_pkg::RES_W-1:0] rc;
		rc = (r > step_seq_pkg::RES_FULL) ? step_seq_pkg::RES_FULL : r;
		width_of = step_seq_pkg::POS_ONE << rc;
	endfunction

	// nearest valid point: grid offset by half a step width
	function automatic logic [step_seq_pkg::POS_W-1:0] snap(
		input logic [step_seq_pkg::POS_W-1:0] p,
		input logic [step_seq_pkg::RES_W-1:0] r);
		logic [step_seq_pkg::POS_W-1:0] w;
		logic [step_seq_pkg::POS_W-1:0] half;
		w    = width_of(r);
		half = w >> 1;
		// floor to grid then add half width: 128/384.. for w=256
		snap = (w == step_seq_pkg::POS_ONE) ? p
			: ((p & ~(w - step_seq_pkg::POS_ONE)) | half);
	endfunction

	localparam logic [step_seq_pkg::TIMER_W-1:0] TIMER_ZERO = '0;

	// codes above full step act as full step, also for the spacing shift
	wire [step_seq_pkg::RES_W-1:0] res_c =
		(i_res > step_seq_pkg::RES_FULL) ? step_seq_pkg::RES_FULL : i_res;
	wire [step_seq_pkg::POS_W-1:0] step_w   = width_of(i_res);
	wire [8:0]  interp_n = step_w[8:0]; // widest width 256 fits
	wire        coarser  = i_res > res_prev;
	wire        do_interp = i_interp_en && (state == step_seq_pkg::ST_MOVING)
	                        && (step_w != step_seq_pkg::POS_ONE);
	wire [step_seq_pkg::TIMER_W-1:0] spacing =
		period >> step_seq_pkg::TIMER_W'(res_c);
	wire        mstep_due = (mstep_left != 9'h000) &&
	                        (mstep_tmr == TIMER_ZERO);
	wire        timeout  = interval == step_seq_pkg::TIMER_MAX;
	// owed microsteps land at once when a new edge cuts a burst short,
	// so the count never drifts from the step pulses
	wire [step_seq_pkg::POS_W-1:0] owed   = {1'b0, mstep_left};
	wire [step_seq_pkg::POS_W-1:0] caught = mdir ? pos - owed : pos + owed;

	// position update: edge, microstep, or resolution snap
	always_comb begin
		next_pos = pos;
		if (sync_bus.step_rise && !do_interp) begin
			// whole step from the caught-up point
			if (sync_bus.dir)
				next_pos = snap(caught, i_res) - step_w;
			else
				next_pos = snap(caught, i_res) + step_w;
		end else if (sync_bus.step_rise) begin
			// new burst cuts the old one: angle jump to its end
			next_pos = caught;
		end else if (mstep_due) begin
			if (mdir)
				next_pos = pos - step_seq_pkg::POS_ONE;
			else
				next_pos = pos + step_seq_pkg::POS_ONE;
		end else if (coarser && mstep_left == 9'h000) begin
			next_pos = snap(pos, i_res);
		end
	end

	// position and resolution history
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			pos      <= step_seq_pkg::POS_ZERO;
			res_prev <= '0;
		end else begin
			pos      <= next_pos;
			res_prev <= i_res;
		end
	end

	// interval measurement, saturating at the measurable limit
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			interval <= '0;
			period   <= step_seq_pkg::TIMER_MAX;
		end else if (sync_bus.step_rise) begin
			interval <= '0;
			period   <= interval; // new rate used for this edge's burst
		end else if (!timeout) begin
			interval <= interval + step_seq_pkg::TIMER_ONE;
		end
	end

	// microstep burst: on an edge, any owed microsteps land as a jump
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			mstep_left <= '0;
			mstep_tmr  <= '0;
			mdir       <= 1'b0;
		end else if (sync_bus.step_rise && do_interp) begin
			// first microstep immediately, jump lands remainder
			mstep_left <= interp_n;
			mstep_tmr  <= '0;
			mdir       <= sync_bus.dir;
		end else if (sync_bus.step_rise) begin
			// a whole step has already landed what was owed
			mstep_left <= '0;
			mstep_tmr  <= '0;
		end else if (mstep_due) begin
			mstep_left <= mstep_left - step_seq_pkg::MSTEP_ONE;
			mstep_tmr  <= spacing;
		end else if (mstep_tmr != TIMER_ZERO) begin
			mstep_tmr  <= mstep_tmr - step_seq_pkg::TIMER_ONE;
		end
	end

	// standstill state: set on timeout, cleared by the next edge
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state <= step_seq_pkg::ST_STILL;
		end else begin
			case (state)
			step_seq_pkg::ST_MOVING: begin
				if (timeout && !sync_bus.step_rise)
					state <= step_seq_pkg::ST_STILL;
			end
			step_seq_pkg::ST_STILL: begin
				if (sync_bus.step_rise)
					state <= step_seq_pkg::ST_MOVING;
			end
			default: state <= step_seq_pkg::ST_STILL;
			endcase
		end
	end

	// index registered so it is glitch free at the pin
	always_ff @(posedge i_core_clk) begin
		if (i_reset)
			index_q <= 1'b0;
		else
			index_q <= next_pos == step_seq_pkg::POS_ZERO;
	end

	// half-step points never hit zero, so index needs fine stepping
	assign o_position   = pos;
	assign o_standstill = state == step_seq_pkg::ST_STILL;
	assign o_standby    = o_standstill & i_power_down_select_pin;
	assign o_index      = index_q;

	property p_dir_up;
		@(posedge i_core_clk) disable iff (i_reset)
		(sync_bus.step_rise && !do_interp && !sync_bus.dir &&
		 step_w == step_seq_pkg::POS_ONE) |=> pos == $past(pos) + 10'h001;
	endproperty
	a_dir_up: assert property (p_dir_up)
		else $error("fine step did not increment");

	property p_dir_down;
		@(posedge i_core_clk) disable iff (i_reset)
		(sync_bus.step_rise && !do_interp && sync_bus.dir &&
		 step_w == step_seq_pkg::POS_ONE) |=> pos == $past(pos) - 10'h001;
	endproperty
	a_dir_down: assert property (p_dir_down)
		else $error("fine step did not decrement");

	property p_full_grid;
		@(posedge i_core_clk) disable iff (i_reset)
		(sync_bus.step_rise && !do_interp && i_res == 4'h8)
		|=> pos[7:0] == 8'h80;
	endproperty
	a_full_grid: assert property (p_full_grid)
		else $error("full step off 128 grid");

	property p_half_grid;
		@(posedge i_core_clk) disable iff (i_reset)
		(sync_bus.step_rise && !do_interp && i_res == 4'h7)
		|=> pos[6:0] == 7'h40;
	endproperty
	a_half_grid: assert property (p_half_grid)
		else $error("half step off 64 grid");

	property p_stst_clear;
		@(posedge i_core_clk) disable iff (i_reset)
		(o_standstill && sync_bus.step_rise) |=> !o_standstill;
	endproperty
	a_stst_clear: assert property (p_stst_clear)
		else $error("standstill not cleared by edge");

	property p_stst_set;
		@(posedge i_core_clk) disable iff (i_reset)
		(timeout && !sync_bus.step_rise) |=> o_standstill;
	endproperty
	a_stst_set: assert property (p_stst_set)
		else $error("timeout did not flag standstill");

	property p_standby;
		@(posedge i_core_clk) disable iff (i_reset)
		o_standby |-> (o_standstill && i_power_down_select_pin);
	endproperty
	a_standby: assert property (p_standby)
		else $error("standby without standstill and select");

	property p_index;
		@(posedge i_core_clk) disable iff (i_reset)
		o_index |-> pos == 10'h000;
	endproperty
	a_index: assert property (p_index)
		else $error("index away from zero point");

	property p_mstep_one;
		@(posedge i_core_clk) disable iff (i_reset)
		(mstep_due && !sync_bus.step_rise) |=>
		(pos - $past(pos) == 10'h001) || ($past(pos) - pos == 10'h001);
	endproperty
	a_mstep_one: assert property (p_mstep_one)
		else $error("microstep not one entry");

	property p_snap;
		@(posedge i_core_clk) disable iff (i_reset)
		(coarser && !sync_bus.step_rise && mstep_left == 9'h000 &&
		 i_res == step_seq_pkg::RES_FULL) |=> pos[7:0] == 8'h80;
	endproperty
	a_snap: assert property (p_snap)
		else $error("coarser resolution left position off grid");

	property p_burst_min;
		@(posedge i_core_clk) disable iff (i_reset)
		(sync_bus.step_rise && do_interp && i_res == 4'h1)
		|=> mstep_left == 9'h002;
	endproperty
	a_burst_min: assert property (p_burst_min)
		else $error("burst at code one is not two microsteps");

	property p_burst_max;
		@(posedge i_core_clk) disable iff (i_reset)
		(sync_bus.step_rise && do_interp &&
		 i_res == step_seq_pkg::RES_FULL) |=> mstep_left == 9'h100;
	endproperty
	a_burst_max: assert property (p_burst_max)
		else $error("full step burst is not 256 microsteps");

	property p_burst_dir;
		@(posedge i_core_clk) disable iff (i_reset)
		(sync_bus.step_rise && do_interp) |=> mdir == $past(sync_bus.dir);
	endproperty
	a_burst_dir: assert property (p_burst_dir)
		else $error("burst direction not taken with its edge");

	property p_jump;
		@(posedge i_core_clk) disable iff (i_reset)
		(sync_bus.step_rise && do_interp && !mdir) |=>
		pos == $past(pos) + {1'b0, $past(mstep_left)};
	endproperty
	a_jump: assert property (p_jump)
		else $error("owed microsteps not landed on new edge");

	c_standstill: cover property (@(posedge i_core_clk) o_standstill
		##1 !o_standstill);
	c_index: cover property (@(posedge i_core_clk) o_index);
	c_burst: cover property (@(posedge i_core_clk) mstep_due);
	c_jump: cover property (@(posedge i_core_clk)
		sync_bus.step_rise && do_interp && mstep_left != 9'h000);
	c_full_step: cover property (@(posedge i_core_clk)
		sync_bus.step_rise && i_res == step_seq_pkg::RES_FULL);
endmodule
`default_nettype wire

// [src/step_input_sync.sv]
// Purpose: synchronises step and direction and finds rising step edges
// Assumes: pins asynchronous to the core clock
// Notes:   first stage flops feed only the second stage
`timescale 1ns/1ps
`default_nettype none
module step_input_sync (
	input  wire logic       i_core_clk, // core clock
	input  wire logic       i_reset,    // sync reset, high
	input  wire logic       i_step,     // step pin
	input  wire logic       i_dir,      // direction pin
	step_sync_if.source     sync_port   // edge and direction out
);
	logic step_meta;
	logic step_sync;
	logic step_prev;
	logic dir_meta;
	logic dir_sync;

	// two-flop synchronisers, then a history flop for the edge
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			step_meta <= 1'b0;
			step_sync <= 1'b0;
			step_prev <= 1'b0;
			dir_meta  <= 1'b0;
			dir_sync  <= 1'b0;
		end else begin
			step_meta <= i_step;
			step_sync <= step_meta;
			step_prev <= step_sync;
			dir_meta  <= i_dir;
			dir_sync  <= dir_meta;
		end
	end

	// falling edges never produce a pulse
	assign sync_port.step_rise = step_sync & ~step_prev;
	assign sync_port.dir       = dir_sync;

	property p_rise_only;
		@(posedge i_core_clk) disable iff (i_reset)
		sync_port.step_rise |-> (step_sync && !step_prev);
	endproperty
	a_rise_only: assert property (p_rise_only)
		else $error("step pulse without rising edge");

	property p_sync_delay;
		@(posedge i_core_clk) disable iff (i_reset)
		sync_port.step_rise |-> $past(i_step, 2) && !$past(i_step, 3);
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("step edge not delayed through synchroniser");
endmodule
`default_nettype wire

// [src/step_seq_pkg.sv]
// Purpose: shared constants for the step/direction microstep sequencer
// Assumes: 100 MHz core clock
// Notes:   table of 1024 entries spans four full steps
package step_seq_pkg;
	localparam int POS_W         = 10;
	localparam int RES_W         = 4;
	localparam int TIMER_W       = 20;
	localparam int INTERP_LOG_MAX = 8;
	localparam logic [RES_W-1:0] RES_FULL = 4'h8;
	localparam logic [POS_W-1:0] POS_ONE  = 10'h001;
	localparam logic [POS_W-1:0] POS_ZERO = 10'h000;
	localparam logic [TIMER_W-1:0] TIMER_MAX = 20'hfffff;
	localparam logic [TIMER_W-1:0] TIMER_ONE = 20'h00001;
	localparam logic [8:0] MSTEP_ONE = 9'h001;

	typedef enum logic [1:0] {
		ST_MOVING = 2'b01,
		ST_STILL  = 2'b10
	} motion_state_type;
endpackage

// [src/step_sync_if.sv]
// Purpose: carries synchronised step edge and direction between modules
// Assumes: single core clock
// Notes:   step_rise is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface step_sync_if;
	logic step_rise; // one-cycle rising edge of step
	logic dir;       // direction captured with that edge
	modport source (output step_rise, output dir);
	modport sink   (input step_rise, input dir);
endinterface
`default_nettype wire

// [tb/step_ctrl_model.sv]
// Purpose: motion controller model that drives the step and direction pins
// Assumes: pins change on the falling core clock edge
// Notes:   direction flips once its hold is over, to probe edge capture
`timescale 1ns/1ps
`default_nettype none
module step_ctrl_model (
	input  wire logic i_core_clk, // core clock
	output var  logic o_step,     // step pin
	output var  logic o_dir       // direction pin
);
	// idle pins at time zero
	initial begin
		o_step = 1'b0;
		o_dir  = 1'b0;
	end
	// one pulse; caller keeps hi and lo at two clocks or more
	task automatic pulse(input logic d, input int hi, input int lo);
		@(negedge i_core_clk) o_dir = d; // setup ahead of the edge
		@(negedge i_core_clk) o_step = 1'b1;
		repeat (hi) @(negedge i_core_clk); // high time legal
		o_step = 1'b0;
		@(negedge i_core_clk) o_dir = ~d; // no kinder: dir moves on
		repeat (lo - 1) @(negedge i_core_clk); // steady period
	endtask
endmodule
`default_nettype wire

// [tb/step_dir_microstep_sequencer_tb_top.sv]
// Purpose: self-checking bench for the step/dir microstep sequencer
// Assumes: coarse steps snap to grid plus half width
// Notes:   the 2^20 clock standstill timeout is too long to run here
`timescale 1ns/1ps
`default_nettype none
module step_dir_microstep_sequencer_tb_top;
	logic                           i_core_clk;
	logic                           i_reset;
	logic                           step_pin;
	logic                           dir_pin;
	logic [step_seq_pkg::RES_W-1:0] i_res;
	logic                           i_power_down_select_pin;
	logic                           i_interp_en;
	logic [step_seq_pkg::POS_W-1:0] o_position;
	logic                           o_standstill;
	logic                           o_standby;
	logic                           o_index;
	logic [step_seq_pkg::POS_W-1:0] exp_q[$];
	logic [step_seq_pkg::POS_W-1:0] exp_pos;
	logic [step_seq_pkg::POS_W-1:0] last_pos;
	logic [step_seq_pkg::POS_W-1:0] base_pos;
	logic                           track;
	int                             n_changes;
	int                             n_errors;
	int                             n_checks;
	int                             seed;
	int                             dir_r;

	step_ctrl_model i_ctrl (.i_core_clk(i_core_clk), .o_step(step_pin),
		.o_dir(dir_pin));
	step_dir_microstep_sequencer i_dut (.i_core_clk(i_core_clk),
		.i_reset(i_reset), .i_step(step_pin), .i_dir(dir_pin),
		.i_res(i_res), .i_power_down_select_pin(i_power_down_select_pin),
		.i_interp_en(i_interp_en), .o_position(o_position),
		.o_standstill(o_standstill), .o_standby(o_standby),
		.o_index(o_index));

	// free running 100 MHz clock
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		n_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic wrap_up();
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// width 1 is already on grid, so it never moves
	function automatic logic [9:0] snap(input logic [9:0] p, input int r);
		logic [9:0] w;
		w = 10'h001 << r;
		if (r == 0)
			return p;
		return (p & ~(w - 10'h001)) | (w >> 1);
	endfunction

	// watcher: while track is set, each position change takes the oldest note; otherwise it is counted
	always @(posedge i_core_clk) begin
		#1;
		if (!i_reset && o_position !== last_pos) begin
			if (!track)
				n_changes++;
			else if (exp_q.size() == 0)
				check(o_position, last_pos); // falling edges inert
			else
				check(o_position, exp_q.pop_front());
		end
		last_pos = o_position;
	end

	// bounded wait for all notes, then the zero point flag
	task automatic drain();
		int k;
		k = 0;
		while (exp_q.size() != 0 && k < 40) begin
			@(negedge i_core_clk);
			k++;
		end
		if (exp_q.size() != 0) begin
			check(16'h0000, 16'hffff);
			wrap_up();
		end
		repeat (2) @(negedge i_core_clk);
		check(o_index, exp_pos == 10'h000);
	endtask

	// one whole step with random but legal pin timing
	task automatic step(input logic d);
		logic [9:0] w;
		w = 10'h001 << i_res;
		exp_pos = snap(d ? exp_pos - w : exp_pos + w, i_res);
		exp_q.push_back(exp_pos);
		// period of 2w clocks or more keeps full steps under clk/512
		i_ctrl.pulse(d, 2 + {$random(seed)} % 4,
			2 * w + {$random(seed)} % 4);
		drain();
	endtask

	// main sequence
	initial begin
		seed = 90768;
		i_reset = 1'b1;
		i_res = 4'h0;
		i_power_down_select_pin = 1'b0;
		i_interp_en = 1'b0;
		track = 1'b1;
		n_errors = 0;
		n_checks = 0;
		n_changes = 0;
		exp_pos = 10'h000;
		last_pos = 10'h000;
		repeat (2) @(posedge i_core_clk);
		@(negedge i_core_clk);
		i_reset = 1'b0;
		@(negedge i_core_clk);
		check(o_standstill, 1'b1);
		check(o_standby, 1'b0);
		i_power_down_select_pin = 1'b1;
		#1 check(o_standby, 1'b1);
		step(1'b1);
		check(o_standstill, 1'b0);
		check(o_standby, 1'b0);
		step(1'b0);
		$display("test wrap and standstill done");
		for (int r = 0; r <= 8; r++) begin
			i_res = r[3:0];
			if (snap(exp_pos, r) != exp_pos)
				exp_q.push_back(snap(exp_pos, r));
			exp_pos = snap(exp_pos, r);
			drain();
			repeat (4) begin
				dir_r = $random(seed);
				step(dir_r[0]);
			end
		end
		$display("test resolution codes done");
		i_res = 4'h1;
		i_interp_en = 1'b1;
		track = 1'b0;
		repeat (2) i_ctrl.pulse(1'b0, 20, 20);
		n_changes = 0;
		base_pos = o_position;
		repeat (4) i_ctrl.pulse(1'b0, 20, 20);
		repeat (30) @(negedge i_core_clk);
		check(n_changes, 16'h0008);
		exp_pos = base_pos + 10'h008;
		check(o_position, exp_pos);
		$display("test interpolation done");
		// slow pulse then fast ones: cut bursts must land as a jump
		i_res = 4'h2;
		repeat (4) @(negedge i_core_clk);
		base_pos = o_position;
		i_ctrl.pulse(1'b0, 20, 20);
		repeat (3) i_ctrl.pulse(1'b0, 3, 3);
		repeat (30) @(negedge i_core_clk);
		exp_pos = base_pos + 10'h010;
		check(o_position, exp_pos);
		$display("test skipped microsteps done");
		wrap_up();
	end
endmodule
`default_nettype wire
